// ===== include/drive_input_pkg.sv
// Constants, codes and carrier types for the input terminal function map
package drive_input_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int NUM_TERMINALS = 5;
	localparam int CODE_W        = 6;
	localparam int ADDR_W        = 8;
	localparam int DATA_W        = 32;
	localparam int NUM_CODES     = 64;
	localparam int SYNC_STAGES   = 2;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_FUNC_SEL1  = 8'h00;
	localparam logic [7:0] OFS_FUNC_SEL2  = 8'h04;
	localparam logic [7:0] OFS_FUNC_SEL3  = 8'h08;
	localparam logic [7:0] OFS_FUNC_SEL4  = 8'h0c;
	localparam logic [7:0] OFS_FUNC_SEL5  = 8'h10;
	localparam logic [7:0] OFS_PULSE_MODE = 8'h14;
	localparam logic [7:0] OFS_POLARITY   = 8'h18;
	localparam logic [7:0] OFS_STATUS     = 8'h1c;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [5:0] RST_FUNC_SEL1  = 6'h01;
	localparam logic [5:0] RST_FUNC_SEL2  = 6'h02;
	localparam logic [5:0] RST_FUNC_SEL3  = 6'h07;
	localparam logic [5:0] RST_FUNC_SEL4  = 6'h0c;
	localparam logic [5:0] RST_FUNC_SEL5  = 6'h0d;
	localparam logic       RST_PULSE_MODE = 1'h0;
	localparam logic [4:0] RST_POLARITY   = 5'h1f;

	////////////////////////////////////////////////////////////////////////////
	// Function codes
	localparam logic [5:0] FN_NONE        = 6'h00;
	localparam logic [5:0] FN_FORWARD_RUN = 6'h01;
	localparam logic [5:0] FN_REVERSE_RUN = 6'h02;
	localparam logic [5:0] FN_THREE_WIRE  = 6'h03;
	localparam logic [5:0] FN_JOG_FORWARD = 6'h04;
	localparam logic [5:0] FN_JOG_REVERSE = 6'h05;
	localparam logic [5:0] FN_COAST_STOP  = 6'h06;
	localparam logic [5:0] FN_FAULT_RESET = 6'h07;
	localparam logic [5:0] FN_RUN_PAUSE   = 6'h08;
	localparam logic [5:0] FN_EXT_FAULT   = 6'h09;
	localparam logic [5:0] FN_FREQ_UP     = 6'h0a;
	localparam logic [5:0] FN_FREQ_DOWN   = 6'h0b;
	localparam logic [5:0] FN_MULTI_BIT1  = 6'h0c;
	localparam logic [5:0] FN_COUNT_TRIG  = 6'h16;
	localparam logic [5:0] FN_COUNT_CLR   = 6'h17;
	localparam logic [5:0] FN_LENGTH_CLR  = 6'h18;
	localparam logic [5:0] FN_SPEED_HOLD  = 6'h19;
	localparam logic [5:0] FN_DC_BRAKE    = 6'h1a;
	localparam logic [5:0] FN_UPDOWN_CLR  = 6'h1b;
	localparam logic [5:0] FN_CMD_KEYPAD  = 6'h1c;
	localparam logic [5:0] FN_CMD_TERM    = 6'h1d;
	localparam logic [5:0] FN_CMD_COMM    = 6'h1e;
	localparam logic [5:0] FN_FREQ_MAIN   = 6'h1f;
	localparam logic [5:0] FN_FREQ_AUX    = 6'h20;
	localparam logic [5:0] FN_HF_CLR      = 6'h21;
	localparam logic [5:0] FN_LAST_USED   = 6'h21;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {CMD_KEYPAD, CMD_TERMINAL, CMD_COMM} cmd_src_t;
	typedef enum logic [1:0] {FSRC_BASE, FSRC_MAIN_X, FSRC_AUX_Y} freq_src_t;

	typedef struct packed {
		logic      jogging;
		logic      decelerating;
		logic      stop_cmd;
		logic      stop_dc_brake;
		logic      freq_src_updown;
		logic      two_wire_mode;
		logic      two_wire_behaviour_setting;
		cmd_src_t  base_cmd_source;
	} drive_state_t;

	typedef struct packed {
		logic       forward_run;
		logic       reverse_run;
		logic       three_wire;
		logic       jog_forward;
		logic       jog_reverse;
		logic       coast_stop;
		logic       fault_reset;
		logic       run_pause;
		logic       ext_fault;
		logic       freq_up;
		logic       freq_down;
		logic [3:0] multistage;
		logic       counter_pulse;
		logic       counter_clear;
		logic       length_clear;
		logic       speed_hold;
		logic       dc_brake_now;
		logic       updown_clear;
		logic       hf_count_clear;
		cmd_src_t   cmd_source;
		freq_src_t  freq_source;
	} func_out_t;

endpackage

// ===== rtl/terminal_conditioner.sv
// One input terminal: synchroniser, polarity and edge detect
module terminal_conditioner
(
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_reset,
	// Pin and setting
	input  wire logic i_pin,
	input  wire logic i_positive,
	// Conditioned terminal
	output logic      o_active,
	output logic      o_rise
);

	logic sync1_reg;
	logic sync2_reg;
	logic active_next;

	// Two-stage synchroniser, first stage read only by the second
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			sync1_reg <= 1'h0;
			sync2_reg <= 1'h0;
		end
		else
		begin
			sync1_reg <= i_pin;
			sync2_reg <= sync1_reg;
		end
	end

	// Polarity: positive keeps the pin sense, otherwise inverted
	assign active_next = i_positive ? sync2_reg : ~sync2_reg;

	// Active level and one-cycle rise pulse
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			o_active <= 1'h0;
			o_rise   <= 1'h0;
		end
		else
		begin
			o_active <= active_next;
			o_rise   <= active_next & ~o_active;
		end
	end

endmodule

// ===== rtl/input_terminal_function_map.sv
// Programmable digital input terminal function map of a motor drive
//
// Local design decisions: the address map and strobed register access.
module input_terminal_function_map
(
	// Clock and reset
	input  wire logic                                     i_sys_clk,
	input  wire logic                                     i_reset,
	// Register port
	input  wire logic [drive_input_pkg::ADDR_W-1:0]        i_addr,
	input  wire logic [drive_input_pkg::DATA_W-1:0]        i_wdata,
	input  wire logic                                     i_wr,
	input  wire logic                                     i_rd,
	output logic      [drive_input_pkg::DATA_W-1:0]        o_rdata,
	// Terminal pins
	input  wire logic [drive_input_pkg::NUM_TERMINALS-1:0] i_terminals,
	// Drive state
	input  wire drive_input_pkg::drive_state_t            i_drive,
	// Decoded functions
	output drive_input_pkg::func_out_t                    o_func,
	output logic                                          o_hf_pulse
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [drive_input_pkg::CODE_W-1:0]        func_sel_reg [drive_input_pkg::NUM_TERMINALS];
	logic                                      pulse_mode_reg;
	logic [drive_input_pkg::NUM_TERMINALS-1:0] polarity_reg;
	logic [drive_input_pkg::NUM_TERMINALS-1:0] term_active;
	logic [drive_input_pkg::NUM_TERMINALS-1:0] term_rise;
	logic [drive_input_pkg::NUM_CODES-1:0]     fn_level;
	logic [drive_input_pkg::NUM_CODES-1:0]     fn_rise;
	drive_input_pkg::cmd_src_t                 cmd_src_next;
	drive_input_pkg::freq_src_t                freq_src_next;
	logic                                      hold_next;
	logic                                      rearm_reg;
	logic                                      to_terminal;
	logic [drive_input_pkg::DATA_W-1:0]        rd_next;

	////////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			func_sel_reg[0] <= drive_input_pkg::RST_FUNC_SEL1;
			func_sel_reg[1] <= drive_input_pkg::RST_FUNC_SEL2;
			func_sel_reg[2] <= drive_input_pkg::RST_FUNC_SEL3;
			func_sel_reg[3] <= drive_input_pkg::RST_FUNC_SEL4;
			func_sel_reg[4] <= drive_input_pkg::RST_FUNC_SEL5;
			pulse_mode_reg  <= drive_input_pkg::RST_PULSE_MODE;
			polarity_reg    <= drive_input_pkg::RST_POLARITY;
		end
		else if (i_wr)
		begin
			unique case (i_addr)
				drive_input_pkg::OFS_FUNC_SEL1:  func_sel_reg[0] <= i_wdata[5:0];
				drive_input_pkg::OFS_FUNC_SEL2:  func_sel_reg[1] <= i_wdata[5:0];
				drive_input_pkg::OFS_FUNC_SEL3:  func_sel_reg[2] <= i_wdata[5:0];
				drive_input_pkg::OFS_FUNC_SEL4:  func_sel_reg[3] <= i_wdata[5:0];
				drive_input_pkg::OFS_FUNC_SEL5:  func_sel_reg[4] <= i_wdata[5:0];
				drive_input_pkg::OFS_PULSE_MODE: pulse_mode_reg  <= i_wdata[0];
				drive_input_pkg::OFS_POLARITY:   polarity_reg    <= i_wdata[4:0];
				default:                         ;
			endcase
		end
	end

	// Read data mux, unmapped reads zero
	always_comb
	begin
		rd_next = '0;
		unique case (i_addr)
			drive_input_pkg::OFS_FUNC_SEL1:  rd_next[5:0] = func_sel_reg[0];
			drive_input_pkg::OFS_FUNC_SEL2:  rd_next[5:0] = func_sel_reg[1];
			drive_input_pkg::OFS_FUNC_SEL3:  rd_next[5:0] = func_sel_reg[2];
			drive_input_pkg::OFS_FUNC_SEL4:  rd_next[5:0] = func_sel_reg[3];
			drive_input_pkg::OFS_FUNC_SEL5:  rd_next[5:0] = func_sel_reg[4];
			drive_input_pkg::OFS_PULSE_MODE: rd_next[0]   = pulse_mode_reg;
			drive_input_pkg::OFS_POLARITY:   rd_next[4:0] = polarity_reg;
			drive_input_pkg::OFS_STATUS:     rd_next[8:0] = {o_func.freq_source, o_func.cmd_source, term_active};
			default:                         rd_next = '0;
		endcase
	end

	// Read data for one cycle after the strobe
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			o_rdata <= '0;
		else if (i_rd)
			o_rdata <= rd_next;
		else
			o_rdata <= '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Terminal conditioning
	genvar g;
	generate
		for (g = 0; g < drive_input_pkg::NUM_TERMINALS; g++)
		begin : gen_term
			terminal_conditioner u_cond
			(
				.i_sys_clk  (i_sys_clk),
				.i_reset    (i_reset),
				.i_pin      (i_terminals[g]),
				.i_positive (polarity_reg[g]),
				.o_active   (term_active[g]),
				.o_rise     (term_rise[g])
			);
		end
	endgenerate

	// Map terminals onto function codes; fifth input leaves in pulse mode
	always_comb
	begin
		fn_level = '0;
		fn_rise  = '0;
		for (int t = 0; t < drive_input_pkg::NUM_TERMINALS; t++)
		begin
			if (!(t == drive_input_pkg::NUM_TERMINALS - 1 && pulse_mode_reg))
			begin
				fn_level[func_sel_reg[t]] = fn_level[func_sel_reg[t]] | term_active[t];
				fn_rise[func_sel_reg[t]]  = fn_rise[func_sel_reg[t]] | term_rise[t];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Source selection and speed hold
	always_comb
	begin
		if (fn_level[drive_input_pkg::FN_CMD_KEYPAD])
			cmd_src_next = drive_input_pkg::CMD_KEYPAD;
		else if (fn_level[drive_input_pkg::FN_CMD_TERM])
			cmd_src_next = drive_input_pkg::CMD_TERMINAL;
		else if (fn_level[drive_input_pkg::FN_CMD_COMM])
			cmd_src_next = drive_input_pkg::CMD_COMM;
		else
			cmd_src_next = i_drive.base_cmd_source;
		if (fn_level[drive_input_pkg::FN_FREQ_MAIN])
			freq_src_next = drive_input_pkg::FSRC_MAIN_X;
		else if (fn_level[drive_input_pkg::FN_FREQ_AUX])
			freq_src_next = drive_input_pkg::FSRC_AUX_Y;
		else
			freq_src_next = drive_input_pkg::FSRC_BASE;
		hold_next = fn_level[drive_input_pkg::FN_SPEED_HOLD] & ~i_drive.stop_cmd
			& ~i_drive.jogging & ~fn_level[drive_input_pkg::FN_JOG_FORWARD] & ~fn_level[drive_input_pkg::FN_JOG_REVERSE];
	end

	// Entry into terminal command control
	assign to_terminal = cmd_src_next == drive_input_pkg::CMD_TERMINAL
		&& o_func.cmd_source != drive_input_pkg::CMD_TERMINAL;

	// Rearm after switch to terminal control in two-wire mode: wait for both run levels to drop
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
			rearm_reg <= 1'h0;
		else if (to_terminal && i_drive.two_wire_mode && i_drive.two_wire_behaviour_setting)
			rearm_reg <= 1'h1;
		else if (!fn_level[drive_input_pkg::FN_FORWARD_RUN] && !fn_level[drive_input_pkg::FN_REVERSE_RUN])
			rearm_reg <= 1'h0;
	end

	// Run state follows terminals only under terminal control
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			o_func.forward_run <= 1'h0;
			o_func.reverse_run <= 1'h0;
		end
		else if (o_func.cmd_source == drive_input_pkg::CMD_TERMINAL && !rearm_reg)
		begin
			o_func.forward_run <= fn_level[drive_input_pkg::FN_FORWARD_RUN];
			o_func.reverse_run <= fn_level[drive_input_pkg::FN_REVERSE_RUN];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered function outputs
	always_ff @(posedge i_sys_clk)
	begin
		if (i_reset)
		begin
			o_func.three_wire     <= 1'h0;
			o_func.jog_forward    <= 1'h0;
			o_func.jog_reverse    <= 1'h0;
			o_func.coast_stop     <= 1'h0;
			o_func.fault_reset    <= 1'h0;
			o_func.run_pause      <= 1'h0;
			o_func.ext_fault      <= 1'h0;
			o_func.freq_up        <= 1'h0;
			o_func.freq_down      <= 1'h0;
			o_func.multistage     <= 4'h0;
			o_func.counter_pulse  <= 1'h0;
			o_func.counter_clear  <= 1'h0;
			o_func.length_clear   <= 1'h0;
			o_func.speed_hold     <= 1'h0;
			o_func.dc_brake_now   <= 1'h0;
			o_func.updown_clear   <= 1'h0;
			o_func.hf_count_clear <= 1'h0;
			o_func.cmd_source     <= drive_input_pkg::CMD_KEYPAD;
			o_func.freq_source    <= drive_input_pkg::FSRC_BASE;
			o_hf_pulse            <= 1'h0;
		end
		else
		begin
			o_func.three_wire     <= fn_level[drive_input_pkg::FN_THREE_WIRE];
			o_func.jog_forward    <= fn_level[drive_input_pkg::FN_JOG_FORWARD];
			o_func.jog_reverse    <= fn_level[drive_input_pkg::FN_JOG_REVERSE];
			o_func.coast_stop     <= fn_level[drive_input_pkg::FN_COAST_STOP];
			o_func.fault_reset    <= fn_rise[drive_input_pkg::FN_FAULT_RESET];
			o_func.run_pause      <= fn_level[drive_input_pkg::FN_RUN_PAUSE];
			o_func.ext_fault      <= fn_level[drive_input_pkg::FN_EXT_FAULT];
			o_func.freq_up        <= fn_level[drive_input_pkg::FN_FREQ_UP] & ~hold_next;
			o_func.freq_down      <= fn_level[drive_input_pkg::FN_FREQ_DOWN] & ~hold_next;
			if (!hold_next)
				o_func.multistage <= fn_level[drive_input_pkg::FN_MULTI_BIT1 +: 4];
			o_func.counter_pulse  <= fn_rise[drive_input_pkg::FN_COUNT_TRIG];
			o_func.counter_clear  <= fn_level[drive_input_pkg::FN_COUNT_CLR];
			o_func.length_clear   <= fn_level[drive_input_pkg::FN_LENGTH_CLR];
			o_func.speed_hold     <= hold_next;
			o_func.dc_brake_now   <= fn_level[drive_input_pkg::FN_DC_BRAKE]
				& i_drive.decelerating & i_drive.stop_dc_brake;
			o_func.updown_clear   <= fn_level[drive_input_pkg::FN_UPDOWN_CLR] & i_drive.freq_src_updown;
			o_func.hf_count_clear <= fn_level[drive_input_pkg::FN_HF_CLR];
			o_func.cmd_source     <= cmd_src_next;
			o_func.freq_source    <= freq_src_next;
			o_hf_pulse            <= pulse_mode_reg & term_active[drive_input_pkg::NUM_TERMINALS-1];
		end
	end
	// Codes above FN_LAST_USED reach no output bit at all

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	a_counter_clear: assert property (fn_level[drive_input_pkg::FN_COUNT_CLR] |=> o_func.counter_clear)
		else $error("counter clear missed");
	a_length_clear: assert property (o_func.length_clear |-> $past(fn_level[drive_input_pkg::FN_LENGTH_CLR]))
		else $error("length clear without terminal");
	a_hold_freezes_speed: assert property (hold_next |=> $stable(o_func.multistage) && !o_func.freq_up && !o_func.freq_down)
		else $error("speed changed during hold");
	a_hold_jog_off: assert property (i_drive.jogging |=> !o_func.speed_hold)
		else $error("hold active while jogging");
	a_dc_brake_cond: assert property (o_func.dc_brake_now |-> $past(i_drive.decelerating && i_drive.stop_dc_brake))
		else $error("dc brake outside decel stop");
	a_updown_clear: assert property (fn_level[drive_input_pkg::FN_UPDOWN_CLR] && i_drive.freq_src_updown
		|=> o_func.updown_clear)
		else $error("up/down clear missed");
	a_cmd_keypad_wins: assert property (fn_level[drive_input_pkg::FN_CMD_KEYPAD]
		|=> o_func.cmd_source == drive_input_pkg::CMD_KEYPAD)
		else $error("keypad priority lost");
	a_run_state_kept: assert property (o_func.cmd_source != drive_input_pkg::CMD_TERMINAL
		|=> $stable(o_func.forward_run) && $stable(o_func.reverse_run))
		else $error("run state changed off terminal");
	a_freq_main_wins: assert property (fn_level[drive_input_pkg::FN_FREQ_MAIN]
		|=> o_func.freq_source == drive_input_pkg::FSRC_MAIN_X)
		else $error("main source priority lost");
	a_hf_clear: assert property (fn_level[drive_input_pkg::FN_HF_CLR] |=> o_func.hf_count_clear)
		else $error("pulse count clear missed");
	a_pulse_input_mode: assert property (!pulse_mode_reg |=> !o_hf_pulse)
		else $error("pulse output in switch mode");
	a_fault_reset_edge: assert property (o_func.fault_reset |=> !o_func.fault_reset)
		else $error("fault reset longer than one cycle");

	c_speed_hold: cover property (o_func.speed_hold ##1 !o_func.speed_hold);
	c_dc_brake: cover property (o_func.dc_brake_now);
	c_fault_reset: cover property (o_func.fault_reset);
	c_to_terminal: cover property (to_terminal ##1 o_func.cmd_source == drive_input_pkg::CMD_TERMINAL);

endmodule

// ===== testbench/switch_bank_model.sv
// Behavioural bank of external contacts wired to the input terminals
module switch_bank_model
#(
	parameter int MIN_HOLD = 4
)
(
	// Clock
	input  wire logic       i_sys_clk,
	// Contact commands, bit0 = terminal one
	input  wire logic [4:0] i_close,
	// Terminal pins, pulled low while a contact is open
	output logic      [4:0] o_pins
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] age_reg [5];

	// Contacts start open, so every pin sits at its pull-down level
	initial
	begin
		o_pins = 5'h00;
		for (int k = 0; k < 5; k++)
			age_reg[k] = 8'h00;
	end

	// A contact only moves after resting MIN_HOLD cycles, so pulse trains stay slow
	always @(posedge i_sys_clk)
	begin
		for (int k = 0; k < 5; k++)
		begin
			if (i_close[k] != o_pins[k] && age_reg[k] >= 8'(MIN_HOLD))
			begin
				o_pins[k] <= i_close[k];
				age_reg[k] <= 8'h00;
			end
			else if (age_reg[k] != 8'hff)
				age_reg[k] <= age_reg[k] + 8'h01;
		end
	end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the input terminal function map
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {logic [5:0] code; logic [25:0] exp;} row_t;

	localparam logic [31:0] RST_VALS [7] = '{32'h01, 32'h02, 32'h07, 32'h0c, 32'h0d, 32'h00, 32'h1f};
	// Code on terminal one beside the decoded outputs it should give while active
	localparam row_t ROWS [30] = '{
		'{6'h00, 26'h0000004}, '{6'h01, 26'h2000004}, '{6'h02, 26'h1000004}, '{6'h03, 26'h0800004},
		'{6'h04, 26'h0400004}, '{6'h05, 26'h0200004}, '{6'h06, 26'h0100004}, '{6'h08, 26'h0040004},
		'{6'h09, 26'h0020004}, '{6'h0a, 26'h0010004}, '{6'h0b, 26'h0008004}, '{6'h0c, 26'h0000804},
		'{6'h0d, 26'h0001004}, '{6'h0e, 26'h0002004}, '{6'h0f, 26'h0004004}, '{6'h15, 26'h0000004},
		'{6'h17, 26'h0000204}, '{6'h18, 26'h0000104}, '{6'h19, 26'h0000084}, '{6'h1a, 26'h0000044},
		'{6'h1b, 26'h0000024}, '{6'h1c, 26'h0000000}, '{6'h1d, 26'h0000004}, '{6'h1e, 26'h0000008},
		'{6'h1f, 26'h0000005}, '{6'h20, 26'h0000006}, '{6'h21, 26'h0000014}, '{6'h22, 26'h0000004},
		'{6'h32, 26'h0000004}, '{6'h3f, 26'h0000004}};

	logic                          clk;
	logic                          rst;
	logic [7:0]                    addr;
	logic [31:0]                   wdata;
	logic                          wr;
	logic                          rd;
	logic [31:0]                   rdata;
	logic [4:0]                    close;
	logic [4:0]                    pins;
	drive_input_pkg::drive_state_t drv;
	drive_input_pkg::func_out_t    func;
	logic                          hf;
	int                            err_count = 0;
	int                            cmp_count = 0;
	int                            n;

	switch_bank_model contacts
	(
		.i_sys_clk (clk),
		.i_close   (close),
		.o_pins    (pins)
	);

	input_terminal_function_map uut
	(
		.i_sys_clk   (clk),
		.i_reset     (rst),
		.i_addr      (addr),
		.i_wdata     (wdata),
		.i_wr        (wr),
		.i_rd        (rd),
		.o_rdata     (rdata),
		.i_terminals (pins),
		.i_drive     (drv),
		.o_func      (func),
		.o_hf_pulse  (hf)
	);

	////////////////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare, bus and stimulus tasks
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_func(input logic [25:0] got, input logic [25:0] exp);
		chk_reg({6'h00, got}, {6'h00, exp});
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_reg(rdata, e);
	endtask

	task automatic set_sel(input logic [5:0] a, b, c, d, e);
		reg_wr(drive_input_pkg::OFS_FUNC_SEL1, {26'h0, a});
		reg_wr(drive_input_pkg::OFS_FUNC_SEL2, {26'h0, b});
		reg_wr(drive_input_pkg::OFS_FUNC_SEL3, {26'h0, c});
		reg_wr(drive_input_pkg::OFS_FUNC_SEL4, {26'h0, d});
		reg_wr(drive_input_pkg::OFS_FUNC_SEL5, {26'h0, e});
	endtask

	// Move the contacts, then wait past the synchroniser and output flops
	task automatic set_pins(input logic [4:0] v);
		@(posedge clk);
		close <= v;
		repeat (8) @(posedge clk);
		#1;
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		close = 5'h00;
		drv = '{jogging: 1'b0, decelerating: 1'b1, stop_cmd: 1'b0, stop_dc_brake: 1'b1, freq_src_updown: 1'b1,
			two_wire_mode: 1'b0, two_wire_behaviour_setting: 1'b0, base_cmd_source: drive_input_pkg::CMD_TERMINAL};
		repeat (9) @(posedge clk);
		#1;
		chk_func(func, 26'h0);
		@(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 7; k++)
			reg_rd(8'(4 * k), RST_VALS[k]);
		reg_wr(drive_input_pkg::OFS_PULSE_MODE, 32'hffff_fffe);
		reg_rd(drive_input_pkg::OFS_PULSE_MODE, 32'h0);
		reg_wr(8'h40, 32'h1);
		reg_rd(8'h40, 32'h0);
		$display("register test done");
		// Ordinary decode table on terminal one
		for (int k = 0; k < 30; k++)
		begin
			set_sel(ROWS[k].code, 6'h02, 6'h07, 6'h0c, 6'h0d);
			set_pins(5'h01);
			chk_func(func, ROWS[k].exp);
			set_pins(5'h00);
			chk_func(func, 26'h0000004);
		end
		$display("decode table done");
		// Edge functions fire once per press
		for (int c = 0; c < 2; c++)
		begin
			set_sel(c == 0 ? 6'h07 : 6'h16, 6'h02, 6'h07, 6'h0c, 6'h0d);
			n = 0;
			for (int k = 0; k < 32; k++)
			begin
				@(posedge clk);
				close <= {4'h0, k[3:0] < 4'h8};
				#1;
				n += int'(func.fault_reset === 1'b1) + int'(func.counter_pulse === 1'b1);
			end
			chk_reg(32'(n), 32'h2);
		end
		$display("edge test done");
		// Polarity per terminal, lowest bit for terminal one
		set_sel(6'h08, 6'h09, 6'h07, 6'h0c, 6'h0d);
		reg_wr(drive_input_pkg::OFS_POLARITY, 32'h1e);
		set_pins(5'h00);
		chk_func(func, 26'h0040004);
		reg_wr(drive_input_pkg::OFS_POLARITY, 32'h1d);
		set_pins(5'h00);
		chk_func(func, 26'h0020004);
		reg_wr(drive_input_pkg::OFS_POLARITY, 32'h1f);
		$display("polarity test done");
		// Speed hold against jog and stop
		set_sel(6'h19, 6'h0a, 6'h07, 6'h0c, 6'h0d);
		set_pins(5'h03);
		chk_func(func, 26'h0000084);
		@(posedge clk);
		drv.jogging <= 1'b1;
		set_pins(5'h03);
		chk_func(func, 26'h0010004);
		@(posedge clk);
		drv.jogging <= 1'b0;
		drv.stop_cmd <= 1'b1;
		set_pins(5'h03);
		chk_func(func, 26'h0010004);
		@(posedge clk);
		drv.stop_cmd <= 1'b0;
		set_pins(5'h00);
		$display("speed hold test done");
		// Braking and up/down clear depend on drive state
		set_sel(6'h1a, 6'h1b, 6'h07, 6'h0c, 6'h0d);
		set_pins(5'h03);
		chk_func(func, 26'h0000064);
		@(posedge clk);
		drv.decelerating <= 1'b0;
		drv.freq_src_updown <= 1'b0;
		set_pins(5'h03);
		chk_func(func, 26'h0000004);
		set_pins(5'h00);
		$display("brake test done");
		// Fifth terminal as pulse input or switch
		set_sel(6'h00, 6'h02, 6'h07, 6'h0c, 6'h19);
		reg_wr(drive_input_pkg::OFS_PULSE_MODE, 32'h1);
		set_pins(5'h10);
		chk_reg({hf, func}, {1'b1, 26'h0000004});
		reg_wr(drive_input_pkg::OFS_PULSE_MODE, 32'h0);
		set_pins(5'h10);
		chk_reg({hf, func}, {1'b0, 26'h0000084});
		set_pins(5'h00);
		$display("pulse mode test done");
		// Source priorities
		set_sel(6'h1e, 6'h1d, 6'h20, 6'h1f, 6'h1c);
		set_pins(5'h05);
		chk_func(func, 26'h000000a);
		set_pins(5'h0f);
		chk_func(func, 26'h0000005);
		set_pins(5'h1f);
		chk_func(func, 26'h0000001);
		set_pins(5'h00);
		$display("priority test done");
		// Run state across command source switches
		set_sel(6'h01, 6'h1c, 6'h07, 6'h0c, 6'h0d);
		@(posedge clk);
		drv.two_wire_mode <= 1'b1;
		drv.two_wire_behaviour_setting <= 1'b1;
		set_pins(5'h02);
		set_pins(5'h03);
		chk_func(func, 26'h0000000);
		set_pins(5'h01);
		chk_func(func, 26'h0000004);
		set_pins(5'h00);
		set_pins(5'h01);
		chk_func(func, 26'h2000004);
		@(posedge clk);
		drv.two_wire_behaviour_setting <= 1'b0;
		set_pins(5'h03);
		chk_func(func, 26'h2000000);
		set_pins(5'h02);
		chk_func(func, 26'h2000000);
		set_pins(5'h00);
		chk_func(func, 26'h0000004);
		$display("run state test done");
		print_verdict();
	end
endmodule
